// file: src/sprc_pkg.sv
// Constants shared by the port control block, the array model and the bench.
// Assumes a single 10 MHz clock and a classic Wishbone register master.
package sprc_pkg;

  // ==========================================================
  // Port geometry
  localparam int ADDR_W = 16;
  localparam int BYTE_W = 9;
  localparam int LANES = 2;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] COUNTER_OFS = 8'h04;
  localparam logic [7:0] MASK_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0c;

  // ==========================================================
  // Control register fields and reset values
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_SOFT_CLEAR_BIT = 1;
  localparam logic CTRL_ENABLE_RST = 1'b1;

  // Status register fields
  localparam int STATUS_SELECTED_BIT = 0;
  localparam int STATUS_MRESET_BIT = 1;

  // Reset values of counter and mask
  localparam logic [ADDR_W-1:0] COUNTER_RST = 16'h0000;
  localparam logic [ADDR_W-1:0] MASK_RST = 16'hffff;

  // ==========================================================
  // Pin synchroniser depth
  localparam int SYNC_STAGES = 2;

endpackage

// file: src/sprc_sync.sv
// Two-flop synchroniser for a bundle of pin inputs.
// Assumes the pins are quasi-static across two clock edges when sampled together.
`timescale 1ns/10ps
`default_nettype none

module sprc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_reg;

  initial begin
    if (W < 1) begin
      $error("sprc_sync width must be at least one");
    end
  end

  // First stage is read only by the second stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= RST_VAL;
      q_o <= RST_VAL;
    end else begin
      meta_reg <= d_i;
      q_o <= meta_reg;
    end
  end

endmodule

`default_nettype wire

// file: src/sprc_port.sv
// Synchronous control of one memory port: byte-lane read/write decode,
// burst address counter with mask, readback onto the address pins, Wishbone regs.
// Assumes an external memory array with one-cycle registered read data.
//
// Design decisions made here: the placing of the registers and register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none

module sprc_port #(
  parameter int ADDR_W = sprc_pkg::ADDR_W,
  parameter int BYTE_W = sprc_pkg::BYTE_W
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Port pins
  input wire logic master_reset_n_i,
  input wire logic output_gate_i,
  input wire logic port_select_active_low_i,
  input wire logic port_select_active_high_i,
  input wire logic upper_byte_select_n_i,
  input wire logic lower_byte_select_n_i,
  input wire logic read_not_write_i,
  input wire logic counter_load_n_i,
  input wire logic counter_advance_n_i,
  input wire logic counter_clear_n_i,
  input wire logic mask_load_n_i,
  input wire logic counter_readback_n_i,
  input wire logic mask_readback_n_i,
  input wire logic [ADDR_W-1:0] addr_i,
  output logic [ADDR_W-1:0] addr_o,
  output logic addr_oe_o,
  input wire logic [2*BYTE_W-1:0] data_i,
  output logic [2*BYTE_W-1:0] data_o,
  output logic [1:0] data_oe_o,
  // Memory array side
  output logic [ADDR_W-1:0] mem_addr_o,
  output logic mem_we_o,
  output logic [1:0] mem_be_o,
  output logic [2*BYTE_W-1:0] mem_wdata_o,
  input wire logic [2*BYTE_W-1:0] mem_rdata_i
);

  localparam int CW = 11;
  localparam int SW = CW + ADDR_W + 2 * BYTE_W;

  initial begin
    if (ADDR_W < 1 || ADDR_W > 32 || BYTE_W < 1 || BYTE_W > 16) begin
      $error("sprc_port parameters out of range");
    end
  end

  // ==========================================================
  // Helpers
  function automatic logic [ADDR_W-1:0] masked_step(input logic [ADDR_W-1:0] cnt,
                                                    input logic [ADDR_W-1:0] mask);
    logic [ADDR_W-1:0] plus;
    plus = cnt + {{(ADDR_W-1){1'b0}}, 1'b1};
    masked_step = (cnt & ~mask) | (plus & mask);
  endfunction

  // ==========================================================
  // Pin synchronisers
  logic [SW-1:0] sync_q;
  logic s_ce_n, s_ce, s_ub_n, s_lb_n, s_rnw, s_load_n, s_adv_n, s_clear_n;
  logic s_mload_n, s_crb_n, s_mrb_n;
  logic [ADDR_W-1:0] s_addr;
  logic [2*BYTE_W-1:0] s_data;

  sprc_sync #(
    .W(SW),
    .RST_VAL({{1'b1, 1'b0, 9'h1ff}, {ADDR_W{1'b0}}, {(2*BYTE_W){1'b0}}})
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({port_select_active_low_i, port_select_active_high_i, upper_byte_select_n_i,
          lower_byte_select_n_i, read_not_write_i, counter_load_n_i, counter_advance_n_i,
          counter_clear_n_i, mask_load_n_i, counter_readback_n_i, mask_readback_n_i,
          addr_i, data_i}),
    .q_o(sync_q)
  );

  assign {s_ce_n, s_ce, s_ub_n, s_lb_n, s_rnw, s_load_n, s_adv_n, s_clear_n,
          s_mload_n, s_crb_n, s_mrb_n, s_addr, s_data} = sync_q;

  // Gate level for synchronous use
  logic gate_meta_reg, gate_reg;
  always_ff @(posedge clk_i) begin
    gate_meta_reg <= output_gate_i;
    gate_reg <= gate_meta_reg;
  end

  // Master reset release synchroniser, asserts at once
  logic mr_meta_reg, mr_ok_reg;
  always_ff @(posedge clk_i or negedge master_reset_n_i) begin
    if (!master_reset_n_i) begin
      mr_meta_reg <= 1'b0;
      mr_ok_reg <= 1'b0;
    end else begin
      mr_meta_reg <= 1'b1;
      mr_ok_reg <= mr_meta_reg;
    end
  end

  // ==========================================================
  // Registers
  logic ctrl_enable_reg, soft_clear_reg;
  logic [ADDR_W-1:0] cnt_reg, mask_reg, used_addr;
  logic clear_act, sel, selected_reg;

  assign clear_act = !s_clear_n || soft_clear_reg;
  assign sel = !s_ce_n && s_ce && ctrl_enable_reg;

  // ==========================================================
  // Counter and mask, independent of selects
  always_comb begin
    if (clear_act) begin
      used_addr = sprc_pkg::COUNTER_RST;
    end else if (!s_mload_n) begin
      used_addr = cnt_reg;
    end else if (!s_load_n) begin
      used_addr = s_addr;
    end else if (!s_adv_n) begin
      used_addr = masked_step(cnt_reg, mask_reg);
    end else begin
      used_addr = cnt_reg;
    end
  end

  always_ff @(posedge clk_i or negedge master_reset_n_i) begin
    if (!master_reset_n_i) begin
      cnt_reg <= sprc_pkg::COUNTER_RST;
      mask_reg <= sprc_pkg::MASK_RST;
    end else if (rst_i) begin
      cnt_reg <= sprc_pkg::COUNTER_RST;
      mask_reg <= sprc_pkg::MASK_RST;
    end else begin
      cnt_reg <= used_addr;
      if (!clear_act && !s_mload_n) begin
        mask_reg <= s_addr;
      end
    end
  end

  // ==========================================================
  // Readback onto the address pins
  always_ff @(posedge clk_i) begin
    if (rst_i || !mr_ok_reg) begin
      addr_oe_o <= 1'b0;
      addr_o <= '0;
    end else if (!s_crb_n) begin
      addr_oe_o <= 1'b1;
      addr_o <= cnt_reg;
    end else if (!s_mrb_n) begin
      addr_oe_o <= 1'b1;
      addr_o <= mask_reg;
    end else begin
      addr_oe_o <= 1'b0;
      addr_o <= '0;
    end
  end

  // ==========================================================
  // Byte-lane access decode
  logic [1:0] lane_be, rd_be_reg, rd_lane_reg;
  assign lane_be = {!s_ub_n, !s_lb_n};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_we_o <= 1'b0;
      mem_be_o <= 2'h0;
      mem_addr_o <= '0;
      mem_wdata_o <= '0;
      rd_be_reg <= 2'h0;
      rd_lane_reg <= 2'h0;
      selected_reg <= 1'b0;
    end else begin
      mem_addr_o <= used_addr;
      mem_wdata_o <= s_data;
      selected_reg <= sel;
      mem_we_o <= sel && !s_rnw && (lane_be != 2'h0);
      mem_be_o <= sel ? lane_be : 2'h0;
      rd_be_reg <= (sel && s_rnw) ? lane_be : 2'h0;
      // Lane enables wait a cycle for the array's registered read data
      rd_lane_reg <= rd_be_reg;
    end
  end

  // Output gate clears the drive without waiting for a clock
  always_ff @(posedge clk_i or posedge output_gate_i) begin
    if (output_gate_i) begin
      data_oe_o <= 2'h0;
    end else if (rst_i || gate_reg) begin
      data_oe_o <= 2'h0;
    end else begin
      data_oe_o <= rd_lane_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_o <= '0;
    end else begin
      data_o <= mem_rdata_i;
    end
  end

  // ==========================================================
  // Wishbone slave
  logic wb_req;
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  // Writes land at the edge where the master sees ack
  logic wb_commit;
  assign wb_commit = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h0000_0000;
      if (wb_req && !wb_we_i) begin
        unique case (wb_adr_i)
          sprc_pkg::CTRL_OFS: wb_dat_o <= {30'h0, 1'b0, ctrl_enable_reg};
          sprc_pkg::COUNTER_OFS: wb_dat_o <= 32'(cnt_reg);
          sprc_pkg::MASK_OFS: wb_dat_o <= 32'(mask_reg);
          sprc_pkg::STATUS_OFS: wb_dat_o <= {30'h0, !mr_ok_reg, selected_reg};
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_enable_reg <= sprc_pkg::CTRL_ENABLE_RST;
      soft_clear_reg <= 1'b0;
    end else begin
      soft_clear_reg <= 1'b0;
      if (wb_commit && wb_sel_i[0] && wb_adr_i == sprc_pkg::CTRL_OFS) begin
        ctrl_enable_reg <= wb_dat_i[sprc_pkg::CTRL_ENABLE_BIT];
        soft_clear_reg <= wb_dat_i[sprc_pkg::CTRL_SOFT_CLEAR_BIT];
      end
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i || !master_reset_n_i);

  chk_clear_zero: assert property (!s_clear_n |=> cnt_reg == '0 && mem_addr_o == '0)
    else $error("counter clear did not give address zero");
  chk_mask_load: assert property (
    s_clear_n && !soft_clear_reg && !s_mload_n
    |=> mask_reg == $past(s_addr) && cnt_reg == $past(cnt_reg))
    else $error("mask load wrong or counter moved");
  chk_cnt_load: assert property (
    !clear_act && s_mload_n && !s_load_n
    |=> cnt_reg == $past(s_addr) && mem_addr_o == $past(s_addr))
    else $error("counter load not taken");
  chk_cnt_advance: assert property (
    !clear_act && s_mload_n && s_load_n && !s_adv_n
    |=> cnt_reg == masked_step($past(cnt_reg), $past(mask_reg)))
    else $error("counter did not advance under mask");
  chk_cnt_hold: assert property (
    !clear_act && s_load_n && s_adv_n |=> $stable(cnt_reg))
    else $error("counter did not hold");
  chk_cnt_readback: assert property (
    mr_ok_reg && !s_crb_n |=> addr_oe_o && addr_o == $past(cnt_reg))
    else $error("counter readback missing");
  chk_mask_readback: assert property (
    mr_ok_reg && s_crb_n && !s_mrb_n |=> addr_oe_o && addr_o == $past(mask_reg))
    else $error("mask readback missing");
  chk_write_lanes: assert property (
    sel && !s_rnw |=> mem_be_o == $past(lane_be) && mem_we_o == ($past(lane_be) != 2'h0))
    else $error("write lanes wrong");
  chk_read_lanes: assert property (
    sel && s_rnw ##2 !gate_reg && !output_gate_i
    |=> output_gate_i || data_oe_o == $past(lane_be, 3))
    else $error("read lanes wrong");
  chk_gate_float: assert property (output_gate_i |-> data_oe_o == 2'h0)
    else $error("data driven while output gate high");
  chk_deselect_idle: assert property (!sel |=> !mem_we_o ##2 data_oe_o == 2'h0)
    else $error("deselected port accessed");
  chk_mreset_state: assert property (
    disable iff (rst_i) !mr_ok_reg
    |-> (cnt_reg == '0 && mask_reg == sprc_pkg::MASK_RST) || $past(master_reset_n_i))
    else $error("master reset did not clear counter");

  cov_burst: cover property (!s_load_n ##1 !s_adv_n [*3]);
  cov_both_write: cover property (sel && !s_rnw && lane_be == 2'h3);
  cov_mask_wrap: cover property (!s_mload_n ##1 !s_adv_n ##1 cnt_reg == '0);
  cov_readback: cover property (!s_crb_n ##1 !s_mrb_n);

endmodule

`default_nettype wire

// file: tb/sprc_mem_model.sv
// Behavioural memory array behind one port: lane-wise writes, registered reads.
// Assumes address, write strobe and lane enables come from the port block.
`timescale 1ns/10ps
`default_nettype none
module sprc_mem_model (
  input wire logic clk_i,
  input wire logic [sprc_pkg::ADDR_W-1:0] addr_i,
  input wire logic we_i,
  input wire logic [1:0] be_i,
  input wire logic [17:0] wdata_i,
  output logic [17:0] rdata_o
);
  logic [17:0] mem [logic [sprc_pkg::ADDR_W-1:0]];
  logic [17:0] msk;
  initial rdata_o = 18'h00000;
  // Unwritten places return a toggling pattern so no stale value looks valid
  always @(posedge clk_i) begin
    msk = {{9{be_i[1]}}, {9{be_i[0]}}};
    rdata_o <= mem.exists(addr_i) ? mem[addr_i] : ~rdata_o;
    if (we_i) begin
      mem[addr_i] = ((mem.exists(addr_i) ? mem[addr_i] : 18'h00000) & ~msk) | (wdata_i & msk);
    end
  end
endmodule
`default_nettype wire

// file: tb/tb_sprc_port.sv
// Self-checking bench for the memory port control block.
// Assumes two sync stages on the pins and the array model on the memory side.
`timescale 1ns/10ps
`default_nettype none
module tb_sprc_port;
  localparam logic [17:0] DAT = 18'h2b4c9;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, master_reset_n_n = 1'b1;
  logic gate = 1'b0, sl = 1'b1, sh = 1'b0, ub_n = 1'b1, lb_n = 1'b1, rnw = 1'b1, a_oe, m_we;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h00000000, rdat, t;
  logic [5:0] n = 6'h3f;
  logic [15:0] a_i = 16'h0000, a_o, m_addr;
  logic [17:0] d_i = 18'h00000, d_o, m_wd, m_rd;
  logic [1:0] d_oe, m_be;
  int mismatches = 0, cmp_count = 0;
  always #50 clk_i = ~clk_i;
  sprc_port dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .master_reset_n_i(master_reset_n_n), .output_gate_i(gate), .port_select_active_low_i(sl),
    .port_select_active_high_i(sh), .upper_byte_select_n_i(ub_n),
    .lower_byte_select_n_i(lb_n), .read_not_write_i(rnw), .counter_load_n_i(n[5]),
    .counter_advance_n_i(n[4]), .counter_clear_n_i(n[3]), .mask_load_n_i(n[2]),
    .counter_readback_n_i(n[1]), .mask_readback_n_i(n[0]), .addr_i(a_i), .addr_o(a_o),
    .addr_oe_o(a_oe), .data_i(d_i), .data_o(d_o), .data_oe_o(d_oe), .mem_addr_o(m_addr),
    .mem_we_o(m_we), .mem_be_o(m_be), .mem_wdata_o(m_wd), .mem_rdata_i(m_rd));
  sprc_mem_model mem_u (.clk_i(clk_i), .addr_i(m_addr), .we_i(m_we), .be_i(m_be),
    .wdata_i(m_wd), .rdata_o(m_rd));
  // ==========================================================
  // Shared tasks
  function automatic logic [17:0] lanes(input logic [1:0] b);
    return {{9{b[1]}}, {9{b[0]}}};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Controls are active low: {load, advance, clear, mask load, cnt rb, mask rb}
  task automatic op(input logic s, input logic [1:0] be, input logic r, input logic [5:0] c,
                    input logic [15:0] a, input logic [17:0] d);
    @(posedge clk_i);
    {sl, sh, ub_n, lb_n, rnw, n, a_i, d_i} <= {~s, s, ~be, r, c, a, d};
    @(posedge clk_i);
    {sl, sh, ub_n, lb_n, n} <= {4'b1011, 6'h3f};
  endtask
  task automatic hunt(input int k, output logic h);
    h = 1'b0;
    for (int i = 0; i < 10 && !h; i++) begin
      @(posedge clk_i);
      h = (k == 0) ? m_we : (k == 1) ? |d_oe : a_oe;
    end
  endtask
  task automatic rb(input logic [5:0] c, input logic [15:0] e);
    logic h;
    op(1'b0, 2'b00, 1'b1, c, 16'h0000, 18'h00000);
    hunt(2, h);
    chk({h, a_o}, {1'b1, e});
  endtask
  task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d,
                    output logic [31:0] r);
    @(posedge clk_i);
    {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, ad, 4'hf, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    r = rdat;
    {cyc, stb, we} <= 3'b000;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_write;
    logic h;
    for (int b = 1; b < 4; b++) begin
      op(1'b1, b[1:0], 1'b0, 6'h1f, 16'h0040 + 16'(b), DAT);
      hunt(0, h);
      chk({h, m_be, m_addr}, {1'b1, b[1:0], 16'h0040 + 16'(b)});
      chk(m_wd & lanes(b[1:0]), DAT & lanes(b[1:0]));
    end
    op(1'b1, 2'b00, 1'b0, 6'h1f, 16'h0050, DAT);
    hunt(0, h);
    chk(h, 1'b0);
    op(1'b0, 2'b11, 1'b0, 6'h1f, 16'h0051, DAT);
    hunt(0, h);
    chk(h, 1'b0);
  endtask
  task automatic t_read;
    logic h;
    for (int b = 1; b < 4; b++) begin
      op(1'b1, b[1:0], 1'b1, 6'h1f, 16'h0043, 18'h00000);
      hunt(1, h);
      chk({h, d_oe}, {1'b1, b[1:0]});
      chk(d_o & lanes(b[1:0]), DAT & lanes(b[1:0]));
    end
    op(1'b0, 2'b11, 1'b1, 6'h1f, 16'h0043, 18'h00000);
    hunt(1, h);
    chk(h, 1'b0);
    @(posedge clk_i);
    gate <= 1'b1;
    op(1'b1, 2'b11, 1'b1, 6'h1f, 16'h0043, 18'h00000);
    hunt(1, h);
    chk(h, 1'b0);
    gate <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask
  task automatic t_counter;
    logic h;
    op(1'b0, 2'b00, 1'b1, 6'h0f, 16'h0010, 18'h00000);
    rb(6'h3d, 16'h0010);
    repeat (3) op(1'b0, 2'b00, 1'b1, 6'h2f, 16'h0000, 18'h00000);
    rb(6'h3d, 16'h0013);
    op(1'b0, 2'b00, 1'b1, 6'h3b, 16'h0003, 18'h00000);
    rb(6'h3e, 16'h0003);
    rb(6'h3c, 16'h0013);
    op(1'b0, 2'b00, 1'b1, 6'h2f, 16'h0000, 18'h00000);
    rb(6'h3d, 16'h0010);
    op(1'b1, 2'b11, 1'b1, 6'h3f, 16'hbeef, 18'h00000);
    rb(6'h3d, 16'h0010);
    op(1'b0, 2'b00, 1'b1, 6'h33, 16'h00ff, 18'h00000);
    rb(6'h3d, 16'h0000);
    rb(6'h3e, 16'h0003);
    op(1'b1, 2'b11, 1'b0, 6'h37, 16'h0055, DAT);
    hunt(0, h);
    chk({h, m_addr}, {1'b1, 16'h0000});
    op(1'b1, 2'b11, 1'b0, 6'h2f, 16'h0055, DAT);
    hunt(0, h);
    chk({h, m_addr}, {1'b1, 16'h0001});
    @(posedge clk_i);
    master_reset_n_n <= 1'b0;
    op(1'b0, 2'b00, 1'b1, 6'h1f, 16'h0077, 18'h00000);
    repeat (4) @(posedge clk_i);
    master_reset_n_n <= 1'b1;
    repeat (3) @(posedge clk_i);
    rb(6'h3d, 16'h0000);
    rb(6'h3e, 16'hffff);
  endtask
  task automatic t_regs;
    logic h;
    wb(1'b0, sprc_pkg::CTRL_OFS, 32'h0, t);
    chk(t, 32'h00000001);
    wb(1'b0, 8'h10, 32'h0, t);
    chk(t, 32'h00000000);
    wb(1'b0, sprc_pkg::MASK_OFS, 32'h0, t);
    chk(t, 32'h0000ffff);
    wb(1'b1, sprc_pkg::CTRL_OFS, 32'h0, t);
    op(1'b1, 2'b11, 1'b0, 6'h1f, 16'h0060, DAT);
    hunt(0, h);
    chk(h, 1'b0);
    // Counter still loads while the port is disabled
    wb(1'b0, sprc_pkg::COUNTER_OFS, 32'h0, t);
    chk(t, 32'h00000060);
    // Enable again and pulse the soft counter clear
    wb(1'b1, sprc_pkg::CTRL_OFS, 32'h3, t);
    wb(1'b0, sprc_pkg::COUNTER_OFS, 32'h0, t);
    chk(t, 32'h00000000);
    wb(1'b0, sprc_pkg::STATUS_OFS, 32'h0, t);
    chk(t, 32'h00000000);
  endtask
  // ==========================================================
  // Run control
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    #(100 * 20000);
    mismatches++;
    finish_test();
  end
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    t_write();
    t_read();
    t_counter();
    t_regs();
    finish_test();
  end
endmodule
`default_nettype wire
